// file: src/ssm_pkg.sv
// Constants, register map and state codes for the stepper motor settings block.
// Assumes the APB byte address of a register is four times its index.
package ssm_pkg;

  localparam int ADDR_W = 12;

  // Register indices; byte address is four times the index.
  localparam logic [9:0] IDX_CFG     = 10'h045;
  localparam logic [9:0] IDX_SCAN_HI = 10'h046;
  localparam logic [9:0] IDX_SCAN_LO = 10'h047;
  localparam logic [9:0] IDX_FEED_HI = 10'h048;
  localparam logic [9:0] IDX_FEED_LO = 10'h049;
  localparam logic [9:0] IDX_SKIP_HI = 10'h04a;
  localparam logic [9:0] IDX_SKIP_LO = 10'h04b;
  localparam logic [9:0] IDX_CNT_HI  = 10'h04c;
  localparam logic [9:0] IDX_CNT_LO  = 10'h04d;
  localparam logic [9:0] IDX_PAUSE   = 10'h04e;
  localparam logic [9:0] IDX_RESUME  = 10'h04f;
  localparam logic [9:0] IDX_REV     = 10'h050;
  localparam logic [9:0] IDX_ACCEL   = 10'h051;
  localparam logic [9:0] IDX_PD_MID  = 10'h052;
  localparam logic [9:0] IDX_PD_LOW  = 10'h053;
  localparam logic [9:0] IDX_LSKIP   = 10'h054;

  // Bit positions in the output configuration register.
  localparam int CFG_MICRO = 0;
  localparam int CFG_SENSE = 1;
  localparam int CFG_POLA  = 2;
  localparam int CFG_POLB  = 3;
  localparam int CFG_EN    = 4;
  localparam int CFG_SWAP  = 5;
  localparam int CFG_FFULL = 6;
  // Bit positions in the line skip register.
  localparam int LSK_BLUE  = 3;
  localparam int LSK_DLY   = 4;

  localparam logic [7:0]  REG_RST    = 8'h00;
  localparam logic [13:0] STEPC_RST  = 14'h0000;
  localparam logic [17:0] MIN_PERIOD = 18'h0_0002;
  localparam logic [17:0] ACC_MAX    = 18'h0_0008;
  localparam logic [1:0]  MICRO_LAST = 2'h3;

  typedef enum logic [8:0] {
    ST_IDLE   = 9'h001,
    ST_FEED   = 9'h002,
    ST_SCAN   = 9'h004,
    ST_REV    = 9'h008,
    ST_PAUSE  = 9'h010,
    ST_WAITPH = 9'h020,
    ST_STOPPD = 9'h040,
    ST_ACC25  = 9'h080,
    ST_ACC50  = 9'h100
  } ssm_state_e;

endpackage

// file: src/ssm_tmr_if.sv
// Link between the motor sequencer and its microstep timer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface ssm_tmr_if;
  logic [17:0] period;
  logic        run;
  logic        step;
  modport tmr (input period, input run, output step);
  modport ctl (output period, output run, input step);
endinterface
`default_nettype wire

// file: src/ssm_step_timer.sv
// Microstep timer: counts pixel periods and pulses once per microstep.
// Assumes pix_tick is a one-cycle pulse from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ssm_step_timer
  import ssm_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pix_tick,
  ssm_tmr_if.tmr    tif
);

  logic [17:0] cnt_q;
  logic        step_q;
  logic [17:0] per;
  logic        wrap;

  // Periods below the minimum are served at the minimum.
  // (R5) clamp scan period
  // (R6) clamp feed period
  assign per  = (tif.period < MIN_PERIOD) ? MIN_PERIOD : tif.period;
  assign wrap = pix_tick && (cnt_q >= per - 18'h0_0001);
  assign tif.step = step_q;

  // Pixel period counter and microstep pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= 18'h0_0000;
      step_q <= 1'b0;
    end else if (!tif.run) begin
      cnt_q  <= 18'h0_0000;
      step_q <= 1'b0;
    end else begin
      step_q <= wrap;
      if (pix_tick) begin
        cnt_q <= wrap ? 18'h0_0000 : cnt_q + 18'h0_0001;
      end
    end
  end

  // A microstep always spans at least two pixel periods.
  property p_gap;
    @(posedge pclk) disable iff (!presetn)
    step_q |=> !step_q;
  endproperty
  a_gap: assert property (p_gap) // (R5)
    else $error("Microstep pulses closer than two pixel periods.");

endmodule
`default_nettype wire

// file: src/ssm_motor.sv
// Stepper motor settings registers and motion sequencer behind an APB slave.
// Assumes pixel, line and buffer fill inputs come from logic on pclk.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// (R1) Phase B polarity 1 makes B outputs active low; keep it 0.
// (R2) Enable 0 tri-states all four phase outputs; 1 drives them.
// (R3) Swap 1 exchanges phase A pair with phase B pair.
// (R4) Fast feed bit 1 forces full-step drive during start feed.
// (R5) Scan microstep lasts a 16-bit pixel period count, at least 2.
// (R6) Feed microstep lasts its own pixel period count, at least 2.
// (R7) Scan start feeds forward up to 32767 full steps at top speed.
// (R8) Two-byte step counter counts full steps from 0 to 16383.
// (R9) Pause when buffer fill reaches count times 2 or 8 kilobytes.
// (R10) Resume when buffer fill falls to count times 2 or 8 kilobytes.
// (R11) On full buffer reverse 0 to 255 full steps; 0 disables.
// (R12) Acceleration: stopped pause, 25% steps, 50% steps, each 0,1,2,8.
// (R13) 18-bit phase difference sets resume time after reversing.
// (R14) 0-7 lines processed after pause and discarded after resume.
// (R15) Colour order bit: 0 red before green, 1 blue before green.
// (R16) Four-bit colour phase delay of 0 to 15 lines.
// (R17) Microstepping needs two-phase current sensing; else full steps.
// (R18) Buffer thresholds are watched continuously during a scan.
module ssm_motor
  import ssm_pkg::*;
#(
  parameter int FILL_W = 16
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              pix_tick,
  input  wire logic              line_tick,
  input  wire logic              scan_start,
  input  wire logic              scan_stop,
  input  wire logic              mem_large,
  input  wire logic [FILL_W-1:0] fill_kb,
  output logic      [3:0]        phase_o,
  output logic      [3:0]        phase_oe_n,
  output logic                   capture_o,
  output logic                   motor_run_o,
  output logic                   colour_blue_first_o,
  output logic      [3:0]        colour_delay_o
);

  localparam int NREG = 16;

  if (FILL_W < 11 || FILL_W > 32) begin : g_chk
    $error("FILL_W must lie between 11 and 32.");
  end

  // Register slot of an index.
  function automatic logic [3:0] rel(input logic [9:0] idx);
    rel = 4'(idx - IDX_CFG);
  endfunction

  // Stage length code to full step units.
  function automatic logic [17:0] acc_units(input logic [1:0] c);
    case (c)
      2'h0:    acc_units = 18'h0_0000;
      2'h1:    acc_units = 18'h0_0001;
      2'h2:    acc_units = 18'h0_0002;
      default: acc_units = ACC_MAX;
    endcase
  endfunction

  // Phase pattern of a full step position, bits A, B, A inverse, B inverse.
  function automatic logic [3:0] full_pat(input logic [1:0] p);
    case (p)
      2'h0:    full_pat = 4'hc;
      2'h1:    full_pat = 4'h6;
      2'h2:    full_pat = 4'h3;
      default: full_pat = 4'h9;
    endcase
  endfunction

  ssm_tmr_if tif ();

  ssm_step_timer u_tmr (
    .pclk     (pclk),
    .presetn  (presetn),
    .pix_tick (pix_tick),
    .tif      (tif)
  );

  logic [7:0]  regs_q [NREG];
  logic [13:0] stepc_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  ssm_state_e  st_q, st_d;
  logic [17:0] cnt_q, cnt_d;
  logic [1:0]  micro_q, pos_q;
  logic        revd_q;
  logic [2:0]  lcnt_q;
  logic        capture_q, run_q;
  logic [3:0]  phase_q, oe_n_q;

  // APB decode and read selection.
  wire  [9:0]  idx     = paddr[ADDR_W-1:2];
  wire         in_map  = (idx >= IDX_CFG) && (idx <= IDX_LSKIP) && (paddr[1:0] == 2'h0);
  wire  [3:0]  roff    = rel(idx);
  wire         setup   = psel && !penable;
  wire         wr_acc  = psel && penable && pready_q && pwrite && in_map;
  wire         wr_chi  = wr_acc && (roff == rel(IDX_CNT_HI));
  wire         wr_clo  = wr_acc && (roff == rel(IDX_CNT_LO));
  wire  [7:0]  rd_byte = (roff == rel(IDX_CNT_HI)) ? {2'h0, stepc_q[13:8]} :
                         (roff == rel(IDX_CNT_LO)) ? stepc_q[7:0] : regs_q[roff];

  // Register fields.
  wire  [7:0]  cfg      = regs_q[rel(IDX_CFG)];
  wire  [15:0] scan_per = {regs_q[rel(IDX_SCAN_HI)], regs_q[rel(IDX_SCAN_LO)]};
  wire  [15:0] feed_per = {regs_q[rel(IDX_FEED_HI)], regs_q[rel(IDX_FEED_LO)]};
  wire  [14:0] skip_n   = {regs_q[rel(IDX_SKIP_HI)][6:0], regs_q[rel(IDX_SKIP_LO)]};
  wire  [7:0]  pause_n  = regs_q[rel(IDX_PAUSE)];
  wire  [7:0]  resume_n = regs_q[rel(IDX_RESUME)];
  wire  [7:0]  rev_n    = regs_q[rel(IDX_REV)];
  wire  [7:0]  accel    = regs_q[rel(IDX_ACCEL)];
  wire  [7:0]  pd_low   = regs_q[rel(IDX_PD_LOW)];
  wire  [7:0]  lskip    = regs_q[rel(IDX_LSKIP)];
  // (R13) phase difference word
  wire  [17:0] pdiff    = {accel[1:0], regs_q[rel(IDX_PD_MID)], pd_low[7:3], 3'h0};
  wire  [2:0]  lines_n  = pd_low[2:0];

  // Buffer thresholds in kilobytes, scaled by memory size.
  // (R9) pause level
  wire  [10:0] pause_kb  = mem_large ? {pause_n, 3'h0} : {2'h0, pause_n, 1'h0};
  // (R10) resume level
  wire  [10:0] resume_kb = mem_large ? {resume_n, 3'h0} : {2'h0, resume_n, 1'h0};
  // (R18) continuous compare
  wire         pause_hit  = (pause_n != 8'h00) && (fill_kb >= FILL_W'(pause_kb));
  wire         resume_hit = fill_kb <= FILL_W'(resume_kb);

  // Motion qualifiers.
  wire         moving  = (st_q == ST_FEED) || (st_q == ST_SCAN) || (st_q == ST_REV) ||
                         (st_q == ST_ACC25) || (st_q == ST_ACC50);
  wire         full_ev = tif.step && (micro_q == MICRO_LAST);
  wire         fwd_ev  = full_ev && moving && (st_q != ST_REV);
  wire  [17:0] dec     = cnt_q - 18'h0_0001;
  // (R17) two-phase sensing needed
  // (R4) full step in start feed
  wire         fullstep = !(cfg[CFG_MICRO] && cfg[CFG_SENSE]) ||
                          ((st_q == ST_FEED) && cfg[CFG_FFULL]);

  // Timer period per state; slower stages stretch the scan period.
  // (R12) 25 and 50 percent speed
  assign tif.period = (st_q == ST_ACC25) ? {scan_per, 2'h0} :
                      (st_q == ST_ACC50) ? {1'h0, scan_per, 1'h0} :
                      ((st_q == ST_FEED) || (st_q == ST_REV)) ? {2'h0, feed_per} :
                      {2'h0, scan_per};
  assign tif.run = moving || (st_q == ST_STOPPD);

  // Phase pattern: full step, or the half step between two positions.
  wire  [1:0]  pos_nx  = (st_q == ST_REV) ? pos_q - 2'h1 : pos_q + 2'h1;
  wire  [3:0]  pat     = (st_q == ST_IDLE) ? 4'h0 :
                         (!fullstep && micro_q[1]) ? (full_pat(pos_q) & full_pat(pos_nx)) :
                         full_pat(pos_q);
  // (R3) swap A pair with B pair
  wire  [3:0]  pat_sw  = cfg[CFG_SWAP] ? {pat[2], pat[3], pat[0], pat[1]} : pat;
  // (R1) winding polarity
  wire  [3:0]  pat_pol = pat_sw ^ {cfg[CFG_POLA], cfg[CFG_POLB], cfg[CFG_POLA], cfg[CFG_POLB]};

  // APB answer: one wait-free access phase after each setup.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup && !in_map;
      prdata_q  <= (setup && in_map) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // Settings registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NREG; i++) begin
        regs_q[i] <= REG_RST;
      end
    end else if (wr_acc && !wr_chi && !wr_clo) begin
      regs_q[roff] <= pwdata[7:0];
    end
  end

  // Full step counter; a software write takes priority over a count.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stepc_q <= STEPC_RST;
    end else if (wr_chi) begin
      stepc_q[13:8] <= pwdata[5:0];
    end else if (wr_clo) begin
      stepc_q[7:0] <= pwdata[7:0];
    end else if (fwd_ev) begin
      // (R8) count forward full steps
      stepc_q <= stepc_q + 14'h0001;
    end
  end

  // Sequencer next state.
  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    case (st_q)
      ST_IDLE: begin
        if (scan_start) begin
          // (R7) load start skip
          st_d  = ST_FEED;
          cnt_d = {3'h0, skip_n};
        end
      end
      ST_FEED: begin
        if (cnt_q == 18'h0_0000) begin
          st_d = ST_SCAN;
        end else if (full_ev) begin
          cnt_d = dec;
        end
      end
      ST_SCAN: begin
        if (pause_hit) begin
          // (R11) reverse or stop
          st_d  = (rev_n != 8'h00) ? ST_REV : ST_PAUSE;
          cnt_d = {10'h000, rev_n};
        end
      end
      ST_REV: begin
        if (cnt_q == 18'h0_0000) begin
          st_d = ST_PAUSE;
        end else if (full_ev) begin
          cnt_d = dec;
        end
      end
      ST_PAUSE: begin
        if (resume_hit) begin
          // (R10) restart motor
          st_d  = revd_q ? ST_WAITPH : ST_STOPPD;
          cnt_d = revd_q ? pdiff : acc_units(accel[3:2]);
        end
      end
      ST_WAITPH: begin
        if (cnt_q == 18'h0_0000) begin
          // (R13) resume after phase wait
          st_d  = ST_STOPPD;
          cnt_d = acc_units(accel[3:2]);
        end else if (pix_tick) begin
          cnt_d = dec;
        end
      end
      ST_STOPPD: begin
        if (cnt_q == 18'h0_0000) begin
          // (R12) stage sequence
          st_d  = ST_ACC25;
          cnt_d = acc_units(accel[5:4]);
        end else if (full_ev) begin
          cnt_d = dec;
        end
      end
      ST_ACC25: begin
        if (cnt_q == 18'h0_0000) begin
          st_d  = ST_ACC50;
          cnt_d = acc_units(accel[7:6]);
        end else if (full_ev) begin
          cnt_d = dec;
        end
      end
      ST_ACC50: begin
        if (cnt_q == 18'h0_0000) begin
          st_d = ST_SCAN;
        end else if (full_ev) begin
          cnt_d = dec;
        end
      end
      default: begin
        st_d  = ST_IDLE;
        cnt_d = 18'h0_0000;
      end
    endcase
    if (scan_stop) begin
      st_d = ST_IDLE;
    end
  end

  // Sequencer state, position and reversal memory.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q    <= ST_IDLE;
      cnt_q   <= 18'h0_0000;
      micro_q <= 2'h0;
      pos_q   <= 2'h0;
      revd_q  <= 1'b0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      if (tif.step) begin
        micro_q <= micro_q + 2'h1;
      end
      if (full_ev && moving) begin
        pos_q <= pos_nx;
      end
      if (st_d == ST_REV) begin
        revd_q <= 1'b1;
      end else if ((st_d == ST_WAITPH) || (st_d == ST_IDLE)) begin
        revd_q <= 1'b0;
      end
    end
  end

  // Capture gating: tail lines after a pause, dropped lines after a resume.
  // (R14) lines without reversal
  wire enter_tail = (st_q == ST_SCAN) && (st_d == ST_PAUSE);
  wire enter_scan = (st_q == ST_ACC50) && (st_d == ST_SCAN) && (rev_n == 8'h00);
  wire capture_d  = ((st_q == ST_SCAN) && (lcnt_q == 3'h0)) ||
                    ((st_q == ST_PAUSE) && !revd_q && (lcnt_q != 3'h0));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lcnt_q    <= 3'h0;
      capture_q <= 1'b0;
    end else begin
      capture_q <= capture_d;
      if (enter_tail || enter_scan) begin
        lcnt_q <= lines_n;
      end else if (line_tick && (lcnt_q != 3'h0)) begin
        lcnt_q <= lcnt_q - 3'h1;
      end
    end
  end

  // Output pins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= 4'h0;
      oe_n_q  <= 4'hf;
      run_q   <= 1'b0;
    end else begin
      phase_q <= pat_pol;
      // (R2) tri-state when disabled
      oe_n_q  <= {4{!cfg[CFG_EN]}};
      run_q   <= st_d != ST_IDLE;
    end
  end

  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign phase_o     = phase_q;
  assign phase_oe_n  = oe_n_q;
  assign capture_o   = capture_q;
  assign motor_run_o = run_q;
  // (R15) colour order
  assign colour_blue_first_o = lskip[LSK_BLUE];
  // (R16) colour phase delay
  assign colour_delay_o      = lskip[LSK_DLY+3:LSK_DLY];

  property p_tri;
    @(posedge pclk) disable iff (!presetn)
    !cfg[CFG_EN] |=> (phase_oe_n == 4'hf);
  endproperty
  a_tri: assert property (p_tri) // (R2)
    else $error("Phase outputs driven while disabled.");

  property p_polb;
    @(posedge pclk) disable iff (!presetn)
    (st_q == ST_IDLE) && cfg[CFG_POLB] && !cfg[CFG_POLA] && !cfg[CFG_SWAP]
      |=> (phase_o == 4'h5);
  endproperty
  a_polb: assert property (p_polb) // (R1)
    else $error("Phase B polarity not applied.");

  property p_feed;
    @(posedge pclk) disable iff (!presetn)
    (st_q == ST_FEED) && (cnt_q == 18'h0_0000) && !scan_stop |=> (st_q == ST_SCAN);
  endproperty
  a_feed: assert property (p_feed) // (R7)
    else $error("Start feed did not hand over to scanning.");

  property p_cnt;
    @(posedge pclk) disable iff (!presetn)
    fwd_ev && !wr_chi && !wr_clo |=> (stepc_q == $past(stepc_q) + 14'h0001);
  endproperty
  a_cnt: assert property (p_cnt) // (R8)
    else $error("Step counter missed a full step.");

  property p_pause;
    @(posedge pclk) disable iff (!presetn)
    (st_q == ST_SCAN) && pause_hit && !scan_stop |=> (st_q inside {ST_REV, ST_PAUSE});
  endproperty
  a_pause: assert property (p_pause) // (R9)
    else $error("Full buffer did not pause the scan.");

  property p_norev;
    @(posedge pclk) disable iff (!presetn)
    (st_q == ST_SCAN) && pause_hit && (rev_n == 8'h00) && !scan_stop |=> (st_q == ST_PAUSE);
  endproperty
  a_norev: assert property (p_norev) // (R11)
    else $error("Reversal taken with zero reverse steps.");

  property p_resume;
    @(posedge pclk) disable iff (!presetn)
    (st_q == ST_PAUSE) && resume_hit && !revd_q && !scan_stop |=> (st_q == ST_STOPPD);
  endproperty
  a_resume: assert property (p_resume) // (R10)
    else $error("Drained buffer did not restart the motor.");

  property p_acc;
    @(posedge pclk) disable iff (!presetn)
    (st_q == ST_ACC25) |-> (tif.period == {scan_per, 2'h0});
  endproperty
  a_acc: assert property (p_acc) // (R12)
    else $error("Quarter speed stage has the wrong period.");

endmodule
`default_nettype wire

// file: testbench/ssm_winding_model.sv
// Model of the motor power stage and windings on the four phase pins.
// Assumes a low enable means the block drives the pin.
`timescale 1ns/1ps
`default_nettype none
module ssm_winding_model (
  input  wire logic       pclk,
  input  wire logic [3:0] phase_o,
  input  wire logic [3:0] phase_oe_n,
  input  wire logic [3:0] act_low,
  output logic      [3:0] pin_lvl,
  output logic      [3:0] energ
);
  logic [3:0] last_q = 4'h0;
  // A released pin has no pull, so it toggles every cycle.
  // released pins float
  assign pin_lvl = (phase_o & ~phase_oe_n) | (~last_q & phase_oe_n);
  // A driven winding carries current at its active level.
  // active level
  assign energ = ~phase_oe_n & ~(pin_lvl ^ ~act_low);
  // Remembers each pin level for the floating pattern.
  always_ff @(posedge pclk) begin
    last_q <= pin_lvl;
  end
endmodule
`default_nettype wire

// file: testbench/test_scanner_stepper_motor_settings.sv
// Self-checking bench for the stepper motor settings block.
// Assumes a one-cycle APB answer and pixel ticks on the same clock.
`timescale 1ns/1ps
`default_nettype none
module test_scanner_stepper_motor_settings;
  import ssm_pkg::*;
  logic              pclk, presetn, psel, penable, pwrite, pix_tick, line_tick;
  logic              scan_start, scan_stop, mem_large, pready, pslverr, capture_o;
  logic              motor_run_o, colour_blue_first_o, err, mv;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, v;
  logic [15:0]       fill_kb;
  logic [3:0]        phase_o, phase_oe_n, colour_delay_o, act_low, pin_lvl, energ, b;
  logic [31:0]       seed = 32'hd647_ae2d;
  logic [31:0]       tk   = 32'hd647_ae2d;
  logic [7:0]        rd;
  int                err_total, cmp_count, mdl[16], k, m;

  ssm_motor #(.FILL_W(16)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pix_tick(pix_tick),
    .line_tick(line_tick), .scan_start(scan_start), .scan_stop(scan_stop),
    .mem_large(mem_large), .fill_kb(fill_kb), .phase_o(phase_o),
    .phase_oe_n(phase_oe_n), .capture_o(capture_o), .motor_run_o(motor_run_o),
    .colour_blue_first_o(colour_blue_first_o), .colour_delay_o(colour_delay_o));
  ssm_winding_model u_wind (.pclk(pclk), .phase_o(phase_o), .phase_oe_n(phase_oe_n),
    .act_low(act_low), .pin_lvl(pin_lvl), .energ(energ));

  // Clock of 40 ns period.
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // Forward order is a right rotate; swapped pairs turn it round.
  function automatic logic [3:0] nxt(input logic [3:0] p, input logic sw);
    return sw ? {p[2:0], p[3]} : {p[0], p[3:1]};
  endfunction

  // Random pixel and line pulses.
  always @(posedge pclk) begin
    tk <= xs(tk);
    pix_tick <= tk[0];
    line_tick <= tk[5] & tk[9];
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  // One APB transfer; the answer is taken at the rising edge that sees pready.
  task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0000_00, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      chk(0, 1, "no pready");
      complete_run();
    end
    rd = prdata[7:0];
    err = pslverr;
    chk(prdata[31:8], 0, "upper read bits");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_step(input int lim);
    logic [3:0] p;
    p = phase_o;
    mv = 1'b0;
    for (int n = 0; n < lim && !mv; n++) begin
      @(negedge pclk);
      mv = (phase_o !== p);
    end
    b = phase_o;
  endtask

  task automatic steps(input int cnt, input logic sw);
    logic [3:0] a;
    a = phase_o;
    for (int i = 0; i < cnt; i++) begin
      wait_step(400);
      chk(mv, 1, "motor stalled");
      if (!mv) begin
        complete_run();
      end
      chk(b, nxt(a, sw), "full step order");
      a = b;
    end
  endtask

  task automatic set_fill(input int f);
    @(posedge pclk);
    fill_kb <= 16'(f);
  endtask

  // Main sequence.
  initial begin
    {psel, penable, pwrite, scan_start, scan_stop, mem_large, presetn} = 7'h00;
    paddr = '0;
    pwdata = '0;
    fill_kb = '0;
    act_low = '0;
    err_total = 0;
    cmp_count = 0;
    do_reset();
    // Reset values, read and write back, unmapped place.
    for (k = 0; k < 16; k++) begin
      apb(1'b0, 10'(IDX_CFG + k), 8'h00);
      chk(rd, 0, "reset value");
    end
    apb(1'b0, 10'h060, 8'h00);
    chk(err, 1, "unmapped error");
    chk(rd, 0, "unmapped data");
    for (k = 0; k < 16; k++) begin
      seed = xs(seed);
      mdl[k] = int'(seed[7:0]) & ((k == 5) ? 8'h7f : 8'hff);
      apb(1'b1, 10'(IDX_CFG + k), 8'(mdl[k]));
    end
    for (k = 0; k < 16; k++) begin
      apb(1'b0, 10'(IDX_CFG + k), 8'h00);
      chk(rd, mdl[k] & ((k == 7) ? 8'h3f : 8'hff), "read back");
    end
    $display("test registers done");
    do_reset();
    // Idle pins under every polarity and enable choice.
    for (k = 0; k < 8; k++) begin
      apb(1'b1, IDX_CFG, {3'h0, k[2], k[1], k[0], 2'b00});
      act_low = {k[0], k[1], k[0], k[1]};
      repeat (2) @(negedge pclk);
      chk(phase_oe_n, k[2] ? 4'h0 : 4'hf, "output enable");
      chk(energ, 0, "idle winding current");
      chk(phase_o, act_low, "idle pin level");
    end
    act_low = '0;
    for (k = 0; k < 4; k++) begin
      seed = xs(seed);
      v = seed;
      apb(1'b1, IDX_LSKIP, v[7:0]);
      @(negedge pclk);
      chk(colour_blue_first_o, v[3], "colour order");
      chk(colour_delay_o, v[7:4], "colour delay");
    end
    $display("test idle outputs done");
    do_reset();
    // Start feed of five full steps, then a very slow scan.
    apb(1'b1, IDX_CFG, 8'h10);
    apb(1'b1, IDX_FEED_LO, 8'h02);
    apb(1'b1, IDX_SKIP_LO, 8'h05);
    apb(1'b1, IDX_SCAN_HI, 8'hff);
    apb(1'b1, IDX_SCAN_LO, 8'hff);
    @(posedge pclk);
    scan_start <= 1'b1;
    @(posedge pclk);
    scan_start <= 1'b0;
    for (k = 0; k < 5000 && capture_o !== 1'b1; k++) @(negedge pclk);
    chk(capture_o, 1, "scan reached");
    if (capture_o !== 1'b1) begin
      complete_run();
    end
    chk(motor_run_o, 1, "motor running");
    apb(1'b0, IDX_CNT_LO, 8'h00);
    chk(rd, 5, "steps after feed");
    apb(1'b0, IDX_CNT_HI, 8'h00);
    chk(rd, 0, "step count high");
    apb(1'b1, IDX_SCAN_HI, 8'h00);
    apb(1'b1, IDX_SCAN_LO, 8'h02);
    steps(4, 1'b0);
    apb(1'b1, IDX_CFG, 8'h30);
    wait_step(400);
    steps(3, 1'b1);
    apb(1'b1, IDX_CFG, 8'h10);
    wait_step(400);
    $display("test feed and scan done");
    // Pause and resume thresholds for the chosen memory size.
    seed = xs(seed);
    @(posedge pclk);
    mem_large <= seed[0];
    m = seed[0] ? 8 : 2;
    apb(1'b1, IDX_PAUSE, 8'h03);
    apb(1'b1, IDX_RESUME, 8'h02);
    set_fill(3 * m - 1);
    steps(2, 1'b0);
    set_fill(3 * m);
    repeat (40) @(negedge pclk);
    wait_step(200);
    chk(mv, 0, "pause at threshold");
    set_fill(2 * m + 1);
    wait_step(200);
    chk(mv, 0, "held above resume");
    set_fill(2 * m);
    steps(2, 1'b0);
    // Reversal on a full buffer, phase wait, then the three stage restart.
    apb(1'b1, IDX_REV, 8'h02);
    apb(1'b1, IDX_PD_LOW, 8'h08);
    apb(1'b1, IDX_ACCEL, 8'h54);
    wait_step(400);
    set_fill(3 * m);
    steps(2, 1'b1);
    wait_step(200);
    chk(mv, 0, "stopped after reversal");
    set_fill(2 * m);
    steps(2, 1'b0);
    @(posedge pclk);
    scan_stop <= 1'b1;
    repeat (2) @(negedge pclk);
    chk(motor_run_o, 0, "stopped");
    @(posedge pclk);
    scan_stop <= 1'b0;
    $display("test pause and resume done");
    complete_run();
  end
endmodule
`default_nettype wire
